// ===== hdl/watchdog_pkg.sv
// shared constants for the watchdog with start-up hold
package watchdog_pkg;
   // ****************************************
   // time base
   // ****************************************
   localparam int unsigned REF_CLK_HZ      = 10_000_000;
   localparam int unsigned SLOW_OSC_HZ     = 31_000;
   localparam int unsigned BASE_TICK_US    = 1_000;
   // slow oscillator cycles per nominal 1 ms base tick
   localparam int unsigned BASE_TICK_CYC   = (SLOW_OSC_HZ / 1_000) * BASE_TICK_US / 1_000;
   localparam int unsigned TICK_CNT_W      = 5;
   // ****************************************
   // period select
   // ****************************************
   localparam int unsigned PERIOD_W        = 5;
   localparam logic [4:0]  PERIOD_RESET    = 5'h0b;  // 2^11 ms, two seconds nominal
   localparam logic [4:0]  PERIOD_MAX      = 5'h12;  // 2^18 ms, 256 s nominal
   localparam int unsigned WDT_CNT_W       = 19;
   // ****************************************
   // control register layout
   // ****************************************
   localparam int unsigned CTRL_W          = 6;
   localparam int unsigned CTRL_EN_BIT     = 0;
   localparam int unsigned CTRL_PS_LSB     = 1;
   localparam int unsigned CTRL_PS_MSB     = 5;
   // ****************************************
   // start-up timer
   // ****************************************
   localparam int unsigned OST_CYCLES      = 1024;
   localparam int unsigned OST_CNT_W       = 11;
   // ****************************************
   // mode field
   // ****************************************
   typedef enum logic [1:0] {
      MODE_OFF   = 2'h0,
      MODE_SOFT  = 2'h1,
      MODE_AWAKE = 2'h2,
      MODE_ON    = 2'h3
   } wdt_mode_t;
endpackage

// ===== hdl/slow_tick_gen.sv
// divides the slow internal oscillator into the 1 ms base tick
`timescale 1ns/1ps
`default_nettype none
module slow_tick_gen
   import watchdog_pkg::*;
#(
   parameter int unsigned DIV = BASE_TICK_CYC
) (
   input  wire logic ref_clk,
   input  wire logic resetn,
   input  wire logic slow_internal_osc,
   input  wire logic restart,
   output logic      osc_edge,
   output logic      ms_tick
);
   logic                  osc_q;
   logic [TICK_CNT_W-1:0] div_q;

   assign osc_edge = slow_internal_osc & ~osc_q;

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) osc_q <= 1'b0;
      else         osc_q <= slow_internal_osc;
   end

   // restart aligns the prescaler with a cleared count so a fresh period is full length
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         div_q   <= '0;
         ms_tick <= 1'b0;
      end else if (restart) begin
         div_q   <= '0;
         ms_tick <= 1'b0;
      end else if (osc_edge) begin
         ms_tick <= (div_q == TICK_CNT_W'(DIV - 1));
         div_q   <= (div_q == TICK_CNT_W'(DIV - 1)) ? '0 : div_q + 1'b1;
      end else begin
         ms_tick <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ===== hdl/startup_timer.sv
// oscillator start-up timer counting crystal input cycles
`timescale 1ns/1ps
`default_nettype none
module startup_timer
   import watchdog_pkg::*;
#(
   parameter int unsigned CYCLES = OST_CYCLES
) (
   input  wire logic ref_clk,
   input  wire logic resetn,
   input  wire logic start,
   input  wire logic crystal_in_pin,
   output logic      running
);
   logic                 xtal_q;
   logic [OST_CNT_W-1:0] cnt_q;

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) xtal_q <= 1'b0;
      else         xtal_q <= crystal_in_pin;
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         running <= 1'b0;
         cnt_q   <= '0;
      end else if (start) begin
         running <= 1'b1;
         cnt_q   <= '0;
      end else if (running && crystal_in_pin && !xtal_q) begin
         running <= (cnt_q != OST_CNT_W'(CYCLES - 1));
         cnt_q   <= cnt_q + 1'b1;
      end
   end
endmodule
`default_nettype wire

// ===== hdl/watchdog_with_startup_hold.sv
// watchdog timer with sleep wake-up and crystal start-up hold
//
// Function
// - the watchdog counts 1 ms base ticks derived from the 31 kHz slow internal oscillator.
// - mode 11 keeps the watchdog active at all times, sleep included.
// - mode 10 keeps the watchdog active while awake and disabled in sleep.
// - mode 01 makes the watchdog active exactly when the soft enable bit is set, sleep or not.
// - the period select field picks a nominal time-out from 1 ms to 256 s.
// - after reset the period select field gives a two-second time-out.
// - the count clears on reset, clear instruction, sleep entry, wake, oscillator fail, disable and start-up timing.
// - entering sleep clears the count, which then counts from zero if still enabled.
// - leaving sleep clears the count and, in crystal modes, holds it at zero until the start-up timer finishes.
// - a time-out during sleep wakes the device instead of resetting it.
// - a time-out during sleep sets the timeout flag; the power-down flag keeps the value set at sleep entry.
// - in crystal modes the start-up timer counts 1024 crystal cycles after power-on, after the power-up delay, and on wake.
// - while the start-up timer runs, execution is held unless fail-safe or two-speed start-up is enabled.
// - the slow oscillator ready flag is set on a slow oscillator edge only while the oscillator is requested, and clears when the request drops.
// - changing the internal oscillator divider leaves the watchdog count alone.
`timescale 1ns/1ps
`default_nettype none
module watchdog_with_startup_hold
   import watchdog_pkg::*;
#(
   parameter int unsigned TICK_DIV   = BASE_TICK_CYC,
   parameter int unsigned OST_COUNT  = OST_CYCLES
) (
   input  wire logic                 ref_clk,
   input  wire logic                 resetn,
   input  wire logic                 slow_internal_osc,
   input  wire logic                 crystal_in_pin,
   input  wire logic [1:0]           watchdog_mode_select,
   input  wire logic                 ctrl_wr,
   input  wire logic [CTRL_W-1:0]    ctrl_wdata,
   input  wire logic                 watchdog_clear_instr,
   input  wire logic                 sleep_enter,
   input  wire logic                 wake_event,
   input  wire logic                 osc_fail,
   input  wire logic                 crystal_mode,
   input  wire logic                 powerup_delay_enable,
   input  wire logic                 powerup_delay_done,
   input  wire logic                 fail_safe_monitor_en,
   input  wire logic                 two_speed_en,
   input  wire logic                 reset_flag_clear,
   output logic [CTRL_W-1:0]         watchdog_control_reg,
   output logic                      watchdog_active,
   output logic [WDT_CNT_W-1:0]      watchdog_count,
   output logic                      device_sleeping,
   output logic                      wdt_reset_req,
   output logic                      wake_req,
   output logic                      timeout_flag,
   output logic                      powerdown_flag,
   output logic                      watchdog_reset_flag,
   output logic                      ost_running,
   output logic                      exec_hold,
   output logic                      slow_osc_enable,
   output logic                      slow_osc_ready_flag
);
   // ****************************************
   // internal signals
   // ****************************************
   logic                 active_d;
   logic                 wake_d;
   logic                 clear_d;
   logic                 timeout_d;
   logic                 ost_start_d;
   logic                 por_pending_q;
   logic                 osc_edge;
   logic                 ms_tick;
   logic [PERIOD_W-1:0]  period_eff;
   logic [WDT_CNT_W-1:0] limit;
   wdt_mode_t            mode;

   assign mode = wdt_mode_t'(watchdog_mode_select);

   // ****************************************
   // control register
   // ****************************************
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         watchdog_control_reg <= {PERIOD_RESET, 1'b0};
      end else if (ctrl_wr) begin
         watchdog_control_reg <= ctrl_wdata;
      end
   end

   // ****************************************
   // mode decode
   // ****************************************
   always_comb begin
      case (mode)
         MODE_ON:    active_d = 1'b1;
         MODE_AWAKE: active_d = ~device_sleeping;
         MODE_SOFT:  active_d = watchdog_control_reg[CTRL_EN_BIT];
         MODE_OFF:   active_d = 1'b0;
         default:    active_d = 1'b0;
      endcase
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) watchdog_active <= 1'b0;
      else         watchdog_active <= active_d;
   end

   // ****************************************
   // time base
   // ****************************************
   // the tick runs off the slow oscillator only, so divider changes on the fast path never reach it
   slow_tick_gen #(
      .DIV (TICK_DIV)
   ) u_tick (
      .ref_clk           (ref_clk),
      .resetn            (resetn),
      .slow_internal_osc (slow_internal_osc),
      .restart           (clear_d),
      .osc_edge          (osc_edge),
      .ms_tick           (ms_tick)
   );

   // oversized selections saturate at the longest period instead of wrapping
   assign period_eff = (watchdog_control_reg[CTRL_PS_MSB:CTRL_PS_LSB] > PERIOD_MAX) ?
                       PERIOD_MAX : watchdog_control_reg[CTRL_PS_MSB:CTRL_PS_LSB];
   assign limit      = (WDT_CNT_W'(1) << period_eff) - WDT_CNT_W'(1);

   // ****************************************
   // sleep and wake
   // ****************************************
   // >= lets a count left above a freshly shortened period expire on the next tick instead of wrapping
   assign timeout_d = active_d && !clear_d && ms_tick && (watchdog_count >= limit);
   assign wake_d    = device_sleeping && (wake_event || timeout_d);

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn)                            device_sleeping <= 1'b0;
      else if (wake_d)                        device_sleeping <= 1'b0;
      else if (sleep_enter && !device_sleeping) device_sleeping <= 1'b1;
   end

   // ****************************************
   // count clearing
   // ****************************************
   assign clear_d = !active_d || watchdog_clear_instr || osc_fail ||
                    (sleep_enter && !device_sleeping) ||
                    (device_sleeping && wake_event) || ost_running;
   // a time-out wake is cleared by the time-out branch below; feeding wake_d back here
   // would close a loop through timeout_d

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn)        watchdog_count <= '0;
      else if (clear_d)   watchdog_count <= '0;
      else if (timeout_d) watchdog_count <= '0;
      else if (ms_tick)   watchdog_count <= watchdog_count + 1'b1;
   end

   // ****************************************
   // time-out outcomes
   // ****************************************
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         wdt_reset_req <= 1'b0;
         wake_req      <= 1'b0;
      end else begin
         wdt_reset_req <= timeout_d && !device_sleeping;
         wake_req      <= wake_d;
      end
   end

   // a clear instruction masks timeout_d, so it wins over a time-out; sleep entry still beats it at the power-down flag
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn)                   timeout_flag <= 1'b0;
      else if (timeout_d)            timeout_flag <= 1'b1;
      else if (watchdog_clear_instr) timeout_flag <= 1'b0;
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn)                              powerdown_flag <= 1'b0;
      else if (sleep_enter && !device_sleeping) powerdown_flag <= 1'b1;
      else if (watchdog_clear_instr)            powerdown_flag <= 1'b0;
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn)                            watchdog_reset_flag <= 1'b0;
      else if (timeout_d && !device_sleeping) watchdog_reset_flag <= 1'b1;
      else if (reset_flag_clear)              watchdog_reset_flag <= 1'b0;
   end

   // ****************************************
   // start-up timer
   // ****************************************
   // the power-on start waits for the power-up delay when that timer is in use
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) por_pending_q <= 1'b1;
      else if (!powerup_delay_enable || powerup_delay_done) por_pending_q <= 1'b0;
   end

   assign ost_start_d = crystal_mode &&
                        ((por_pending_q && (!powerup_delay_enable || powerup_delay_done)) || wake_d);

   startup_timer #(
      .CYCLES (OST_COUNT)
   ) u_ost (
      .ref_clk        (ref_clk),
      .resetn         (resetn),
      .start          (ost_start_d),
      .crystal_in_pin (crystal_in_pin),
      .running        (ost_running)
   );

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) exec_hold <= 1'b0;
      else         exec_hold <= ost_running && !fail_safe_monitor_en && !two_speed_en;
   end

   // ****************************************
   // slow oscillator request and ready
   // ****************************************
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) slow_osc_enable <= 1'b0;
      else         slow_osc_enable <= active_d || powerup_delay_enable || fail_safe_monitor_en;
   end

   // ready needs a real edge from the oscillator, not just the request
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn)              slow_osc_ready_flag <= 1'b0;
      else if (!slow_osc_enable) slow_osc_ready_flag <= 1'b0;
      else if (osc_edge)        slow_osc_ready_flag <= 1'b1;
   end

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   a_mode_always_on: assert property (mode == MODE_ON |=> watchdog_active)
      else $error("watchdog inactive in always-on mode");
   a_mode_sleep_off: assert property (mode == MODE_AWAKE && device_sleeping |=> !watchdog_active)
      else $error("watchdog active in sleep for awake-only mode");
   a_mode_soft_en: assert property (mode == MODE_SOFT |=> watchdog_active == $past(watchdog_control_reg[CTRL_EN_BIT]))
      else $error("soft mode activity does not follow enable bit");
   a_mode_off_idle: assert property (mode == MODE_OFF |=> !watchdog_active && watchdog_count == '0)
      else $error("watchdog running in off mode");
   a_clear_instr: assert property (watchdog_clear_instr |=> watchdog_count == '0)
      else $error("clear instruction did not clear count");
   a_sleep_entry: assert property (sleep_enter && !device_sleeping |=> watchdog_count == '0 && device_sleeping)
      else $error("sleep entry did not clear count");
   a_ost_hold: assert property (ost_running |=> watchdog_count == '0)
      else $error("count moved while start-up timer ran");
   a_sleep_wake: assert property (timeout_d && device_sleeping |=> wake_req && !wdt_reset_req ##1 !wake_req)
      else $error("sleep time-out did not wake cleanly");
   a_sleep_flags: assert property (timeout_d && device_sleeping |=> timeout_flag && powerdown_flag && !device_sleeping)
      else $error("sleep time-out flags wrong");
   a_awake_reset: assert property (timeout_d && !device_sleeping |=> wdt_reset_req && watchdog_reset_flag)
      else $error("awake time-out did not request reset");
   a_exec_hold: assert property (ost_running && !fail_safe_monitor_en && !two_speed_en |=> exec_hold)
      else $error("execution not held during start-up timing");
   a_count_steps: assert property (watchdog_count != $past(watchdog_count) && watchdog_count != '0 |-> $past(ms_tick))
      else $error("count advanced without a base tick");
   a_osc_fail_clear: assert property (osc_fail |=> watchdog_count == '0)
      else $error("oscillator fail did not clear count");
   a_wake_clear: assert property (wake_req |-> watchdog_count == '0)
      else $error("count not clear after wake");
   a_ost_start: assert property (ost_start_d |=> ost_running)
      else $error("start-up timer did not start");
   a_ready_drop: assert property (!slow_osc_enable |=> !slow_osc_ready_flag)
      else $error("ready flag set without oscillator request");
endmodule
`default_nettype wire

// ===== verification/watchdog_with_startup_hold_tb.sv
// self-checking bench for the watchdog with start-up hold
`timescale 1ns/1ps
`default_nettype none
module watchdog_with_startup_hold_tb
   import watchdog_pkg::*;
;
   // ****************************************
   // signals
   // ****************************************
   logic                 ref_clk              = 1'b0;
   logic                 resetn               = 1'b0;
   logic                 slow_internal_osc    = 1'b0;
   logic                 crystal_in_pin       = 1'b0;
   logic [1:0]           watchdog_mode_select = 2'h0;
   logic                 ctrl_wr              = 1'b0;
   logic [CTRL_W-1:0]    ctrl_wdata           = 6'h00;
   logic                 watchdog_clear_instr = 1'b0;
   logic                 sleep_enter          = 1'b0;
   logic                 wake_event           = 1'b0;
   logic                 osc_fail             = 1'b0;
   logic                 fail_safe_monitor_en = 1'b0;
   logic                 two_speed_en         = 1'b0;
   logic                 reset_flag_clear     = 1'b0;
   logic [CTRL_W-1:0]    watchdog_control_reg;
   logic                 watchdog_active;
   logic [WDT_CNT_W-1:0] watchdog_count;
   logic                 device_sleeping;
   logic                 wdt_reset_req;
   logic                 wake_req;
   logic                 timeout_flag;
   logic                 powerdown_flag;
   logic                 watchdog_reset_flag;
   logic                 ost_running;
   logic                 exec_hold;
   logic                 slow_osc_enable;
   logic                 slow_osc_ready_flag;
   logic                 div_q                = 1'b0;
   logic                 exp_on;
   int                   err_count            = 0;
   int                   total_checks         = 0;
   int                   req_seen             = 0;
   int                   cyc;
   int                   r;
   int                   lo;

   always #50 ref_clk = ~ref_clk;

   // both slow inputs run free at a quarter of the clock rate, one clock apart
   always @(posedge ref_clk) begin
      div_q <= ~div_q;
      if (div_q) begin
         slow_internal_osc <= ~slow_internal_osc;
      end else begin
         crystal_in_pin <= ~crystal_in_pin;
      end
   end

   always @(posedge ref_clk) begin
      if (wdt_reset_req === 1'b1) begin
         req_seen <= req_seen + 1;
      end
   end

   // small counts keep every time-out within a few hundred cycles
   watchdog_with_startup_hold #(.TICK_DIV(2), .OST_COUNT(4)) dut (
      .ref_clk(ref_clk), .resetn(resetn), .slow_internal_osc(slow_internal_osc),
      .crystal_in_pin(crystal_in_pin), .watchdog_mode_select(watchdog_mode_select),
      .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .watchdog_clear_instr(watchdog_clear_instr),
      .sleep_enter(sleep_enter), .wake_event(wake_event), .osc_fail(osc_fail), .crystal_mode(1'b1),
      .powerup_delay_enable(1'b0), .powerup_delay_done(1'b0), .fail_safe_monitor_en(fail_safe_monitor_en),
      .two_speed_en(two_speed_en), .reset_flag_clear(reset_flag_clear), .watchdog_control_reg(watchdog_control_reg),
      .watchdog_active(watchdog_active), .watchdog_count(watchdog_count), .device_sleeping(device_sleeping),
      .wdt_reset_req(wdt_reset_req), .wake_req(wake_req), .timeout_flag(timeout_flag),
      .powerdown_flag(powerdown_flag), .watchdog_reset_flag(watchdog_reset_flag), .ost_running(ost_running),
      .exec_hold(exec_hold), .slow_osc_enable(slow_osc_enable), .slow_osc_ready_flag(slow_osc_ready_flag)
   );

   // ****************************************
   // tasks
   // ****************************************
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %s expected %0h seen %0h", name, exp, got);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   task automatic write_ctrl(input logic [4:0] ps, input logic en);
      @(posedge ref_clk);
      ctrl_wr    <= 1'b1;
      ctrl_wdata <= {ps, en};
      @(posedge ref_clk);
      ctrl_wr    <= 1'b0;
   endtask

   // 0 clear instruction, 1 sleep, 2 wake, 3 reset flag clear
   task automatic pulse(input int k);
      @(posedge ref_clk);
      case (k)
         0: watchdog_clear_instr <= 1'b1;
         1: sleep_enter <= 1'b1;
         2: wake_event <= 1'b1;
         default: reset_flag_clear <= 1'b1;
      endcase
      @(posedge ref_clk);
      {watchdog_clear_instr, sleep_enter, wake_event, reset_flag_clear} <= 4'h0;
   endtask

   function automatic logic pick(input int k);
      return (k == 0) ? wdt_reset_req : (k == 1) ? wake_req : ost_running;
   endfunction

   // bounded wait until the chosen output shows lvl; cyc holds the edges waited
   task automatic wait_out(input int k, input logic lvl, input int lim);
      cyc = 0;
      while (pick(k) !== lvl && cyc < lim) begin
         @(posedge ref_clk);
         cyc++;
      end
   endtask

   task automatic stop_test;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   initial begin
      #(5_000 * 100);
      err_count++;
      $display("[ERR] run state expected done seen hang");
      stop_test();
   end

   // ****************************************
   // tests
   // ****************************************
   initial begin
      tick(11);
      check("ctrl reset", 32'h0000_0016, watchdog_control_reg);
      check("count reset", 32'h0000_0000, watchdog_count);
      tick(1);
      resetn <= 1'b1;
      wait_out(2, 1'b1, 10);
      check("por start-up run", 1, ost_running);
      tick(2);
      check("por exec hold", 1, exec_hold);
      wait_out(2, 1'b0, 40);
      check("start-up length", 1, cyc + 2 >= 13 && cyc + 2 <= 19);
      tick(2);
      check("exec hold end", 0, exec_hold);
      $display("test power-on start-up done");

      for (int m = 0; m < 4; m++) begin
         for (int s = 0; s < 2; s++) begin
            watchdog_mode_select <= m[1:0];
            two_speed_en         <= s[0];
            write_ctrl(PERIOD_RESET, s[0]);
            tick(3);
            exp_on = (m >= 2) || (m == 1 && s == 1);
            check("active awake", exp_on, watchdog_active);
            check("ctrl write", {PERIOD_RESET, s[0]}, watchdog_control_reg);
            check("slow osc enable", exp_on, slow_osc_enable);
            pulse(1);
            tick(2);
            check("sleeping", 1, device_sleeping);
            check("powerdown flag", 1, powerdown_flag);
            check("count at sleep", 0, watchdog_count);
            exp_on = (m == 3) || (m == 1 && s == 1);
            check("active asleep", exp_on, watchdog_active);
            pulse(2);
            tick(2);
            check("awake again", 0, device_sleeping);
            check("wake start-up", 1, ost_running);
            check("count held", 0, watchdog_count);
            check("wake exec hold", !s[0], exec_hold);
            wait_out(2, 1'b0, 40);
            check("start-up end", 0, ost_running);
         end
      end
      two_speed_en <= 1'b0;
      $display("test mode table done");

      watchdog_mode_select <= MODE_ON;
      for (int ps = 0; ps < 4; ps++) begin
         write_ctrl(ps[4:0], 1'b0);
         pulse(0);
         lo = 8 << ps;
         wait_out(0, 1'b1, 200);
         check("time-out cycles", 1, cyc >= lo - 4 && cyc <= lo + 10);
         check("reset flag", 1, watchdog_reset_flag);
         check("timeout flag", 1, timeout_flag);
         check("slow osc ready", 1, slow_osc_ready_flag);
         pulse(3);
         tick(1);
         check("reset flag clear", 0, watchdog_reset_flag);
         pulse(0);
         tick(1);
         check("clear timeout flag", 0, timeout_flag);
         check("clear count", 0, watchdog_count);
      end
      $display("test awake time-out done");

      // a failing oscillator must keep the count at zero for longer than a period
      pulse(0);
      osc_fail <= 1'b1;
      r = req_seen;
      tick(100);
      check("osc fail count", 0, watchdog_count);
      check("osc fail no reset", r, req_seen);
      osc_fail <= 1'b0;
      $display("test oscillator fail done");

      fail_safe_monitor_en <= 1'b1;
      write_ctrl(PERIOD_RESET, 1'b0);
      pulse(0);
      pulse(1);
      r = req_seen;
      write_ctrl(5'h00, 1'b0);
      wait_out(1, 1'b1, 100);
      check("sleep wake req", 1, wake_req);
      check("woken", 0, device_sleeping);
      check("sleep timeout flag", 1, timeout_flag);
      tick(3);
      check("wake start-up", 1, ost_running);
      check("fail-safe no hold", 0, exec_hold);
      check("no sleep reset", r, req_seen);
      fail_safe_monitor_en <= 1'b0;
      $display("test sleep time-out done");
      stop_test();
   end
endmodule
`default_nettype wire
